// File: hw/ttca_time_tag.sv
`timescale 1ns/100ps
module ttca_time_tag
	import ttca_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire ttca_req_t req,
	output logic [DATA_W-1:0] rdData,
	output logic rdValid,
	input wire logic bcTick,
	input wire logic rtTick,
	input wire logic bcLoad,
	input wire logic bcCapture
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	ttca_ctrl_t ctrl;
	logic [31:0] bcCount;
	logic [15:0] bcStageLo;
	logic [15:0] bcStageHi;
	logic [15:0] rtCount;
	logic [15:0] rtStaging;
	logic wide;
	logic ctrlWr;
	logic [31:0] bcStageWord;
	logic [31:0] next_bcCount;

	assign wide = ctrl.bcWideCountSelect;
	assign ctrlWr = req.wrEn && req.addr == ADDR_CTRL;
	// narrow mode ignores the high staging word entirely
	assign bcStageWord = wide ? {bcStageHi, bcStageLo} : {WORD_ZERO, bcStageLo};

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// a host write wins over the self-clear so a fresh request is never lost
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl <= '{rtAction: TTCA_ACT_NONE, bcWideCountSelect: 1'b0};
		end else if (ctrlWr) begin
			ctrl.bcWideCountSelect <= req.wrData[CTRL_WIDE_BIT];
			ctrl.rtAction <= ttca_action_t'(req.wrData[CTRL_ACT_HI:CTRL_ACT_LO]);
		end else begin
			ctrl.rtAction <= TTCA_ACT_NONE;
		end
	end

	// ----------------------------------------
	// bus-controller counter
	// ----------------------------------------
	// a load takes priority over counting in the same cycle
	always_comb begin
		next_bcCount = bcCount;
		if (bcLoad) begin
			next_bcCount = bcStageWord;
		end else if (bcTick) begin
			next_bcCount = bcCount + 32'h0000_0001;
		end
		if (!wide) begin
			next_bcCount[31:16] = WORD_ZERO;
		end
	end

	// full 32-bit carry passes when wide
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bcCount <= BC_ZERO;
		end else begin
			bcCount <= next_bcCount;
		end
	end

	// staging words: host writes, capture copies the live count
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bcStageLo <= WORD_ZERO;
			bcStageHi <= WORD_ZERO;
		end else if (bcCapture) begin
			bcStageLo <= bcCount[15:0];
			if (wide) begin
				bcStageHi <= bcCount[31:16];
			end
		end else if (req.wrEn) begin
			if (req.addr == ADDR_BC_STAGE_LO) begin
				bcStageLo <= req.wrData;
			end
			if (req.addr == ADDR_BC_STAGE_HI && wide) begin
				bcStageHi <= req.wrData;
			end
		end
	end

	// ----------------------------------------
	// remote-terminal counter
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rtStaging <= WORD_ZERO;
		end else if (req.wrEn && req.addr == ADDR_RT_STAGE) begin
			rtStaging <= req.wrData;
		end
	end

	// clear and load act one cycle after the write and beat the tick
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rtCount <= WORD_ZERO;
		end else begin
			unique case (ctrl.rtAction)
				TTCA_ACT_CLEAR: rtCount <= WORD_ZERO;
				TTCA_ACT_LOAD: rtCount <= rtStaging;
				TTCA_ACT_NONE, TTCA_ACT_IDLE: begin
					if (rtTick) begin
						rtCount <= rtCount + 16'h0001;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// one-cycle latency; unmapped addresses answer zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData <= WORD_ZERO;
			rdValid <= 1'b0;
		end else begin
			rdValid <= req.rdEn;
			if (req.rdEn) begin
				unique case (req.addr)
					ADDR_CTRL: begin
						rdData <= WORD_ZERO;
						rdData[CTRL_WIDE_BIT] <= wide;
						rdData[CTRL_ACT_HI:CTRL_ACT_LO] <= ctrl.rtAction;
					end
					ADDR_BC_COUNT_LO: rdData <= bcCount[15:0];
					ADDR_BC_COUNT_HI: rdData <= bcCount[31:16];
					ADDR_BC_STAGE_LO: rdData <= bcStageLo;
					ADDR_BC_STAGE_HI: rdData <= wide ? bcStageHi : WORD_ZERO;
					ADDR_RT_COUNT: rdData <= rtCount;
					ADDR_RT_STAGE: rdData <= rtStaging;
					default: rdData <= WORD_ZERO;
				endcase
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_narrow_upper: assert property (@(posedge mclk) disable iff (rst)
		!wide |=> (bcCount[31:16] == WORD_ZERO || $past(wide)))
		else $error("narrow counter has upper bits set");
	a_narrow_wrap: assert property (@(posedge mclk) disable iff (rst)
		!wide && bcTick && !bcLoad && bcCount[15:0] == WORD_ONES && !ctrlWr
		|=> bcCount == BC_ZERO)
		else $error("narrow counter did not wrap to zero");
	a_read_low: assert property (@(posedge mclk) disable iff (rst)
		req.rdEn && req.addr == ADDR_BC_COUNT_LO |=> rdData == $past(bcCount[15:0]) && rdValid)
		else $error("low count read mismatch");
	a_narrow_load: assert property (@(posedge mclk) disable iff (rst)
		bcLoad && !wide && !ctrlWr |=> bcCount == {WORD_ZERO, $past(bcStageLo)})
		else $error("narrow load used wrong staging");
	a_wide_carry: assert property (@(posedge mclk) disable iff (rst)
		wide && bcTick && !bcLoad && bcCount[15:0] == WORD_ONES && !ctrlWr
		|=> bcCount[31:16] == $past(bcCount[31:16]) + 16'h0001)
		else $error("wide counter did not carry");
	a_read_high: assert property (@(posedge mclk) disable iff (rst)
		req.rdEn && req.addr == ADDR_BC_COUNT_HI |=> rdData == $past(bcCount[31:16]))
		else $error("high count read mismatch");
	a_wide_load: assert property (@(posedge mclk) disable iff (rst)
		bcLoad && wide && !ctrlWr |=> bcCount == {$past(bcStageHi), $past(bcStageLo)})
		else $error("wide load used wrong staging");
	a_ctrl_zeros: assert property (@(posedge mclk) disable iff (rst)
		req.rdEn && req.addr == ADDR_CTRL |=> (rdData & 16'hfcf7) == WORD_ZERO)
		else $error("unused control bits read nonzero");
	a_action_clear: assert property (@(posedge mclk) disable iff (rst)
		ctrl.rtAction != TTCA_ACT_NONE && !ctrlWr |=> ctrl.rtAction == TTCA_ACT_NONE)
		else $error("action field did not self clear");
	a_rt_zero: assert property (@(posedge mclk) disable iff (rst)
		ctrlWr && req.wrData[CTRL_ACT_HI:CTRL_ACT_LO] == TTCA_ACT_CLEAR ##1 !ctrlWr
		|=> rtCount == WORD_ZERO)
		else $error("clear action did not zero counter");
	a_rt_load: assert property (@(posedge mclk) disable iff (rst)
		ctrl.rtAction == TTCA_ACT_LOAD |=> rtCount == $past(rtStaging))
		else $error("load action did not copy staging");
	a_rt_idle: assert property (@(posedge mclk) disable iff (rst)
		ctrl.rtAction == TTCA_ACT_IDLE && !rtTick |=> $stable(rtCount))
		else $error("idle code changed counter");
	// narrow mode must leave the high staging word untouched and hidden
	a_stage_hi_keep: assert property (@(posedge mclk) disable iff (rst)
		req.wrEn && req.addr == ADDR_BC_STAGE_HI && !wide && !bcCapture
		|=> $stable(bcStageHi))
		else $error("narrow mode wrote high staging");
	a_stage_hi_zero: assert property (@(posedge mclk) disable iff (rst)
		req.rdEn && req.addr == ADDR_BC_STAGE_HI && !wide |=> rdData == WORD_ZERO)
		else $error("narrow mode high staging read nonzero");

	c_wide_carry: cover property (@(posedge mclk) disable iff (rst)
		wide && bcTick && bcCount[15:0] == WORD_ONES);
	c_rt_load: cover property (@(posedge mclk) disable iff (rst)
		ctrl.rtAction == TTCA_ACT_LOAD);
	c_bc_capture: cover property (@(posedge mclk) disable iff (rst)
		bcCapture && wide);
	c_narrow_wrap: cover property (@(posedge mclk) disable iff (rst)
		!wide && bcTick && bcCount[15:0] == WORD_ONES);
	c_rt_clear: cover property (@(posedge mclk) disable iff (rst)
		ctrl.rtAction == TTCA_ACT_CLEAR);
endmodule

// File: hw/ttca_pkg.sv
package ttca_pkg;
	// register map, byte-wide register addresses
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] ADDR_CTRL = 8'h42;
	localparam logic [7:0] ADDR_BC_COUNT_LO = 8'h43;
	localparam logic [7:0] ADDR_BC_COUNT_HI = 8'h44;
	localparam logic [7:0] ADDR_BC_STAGE_LO = 8'h45;
	localparam logic [7:0] ADDR_BC_STAGE_HI = 8'h46;
	localparam logic [7:0] ADDR_RT_COUNT = 8'h49;
	localparam logic [7:0] ADDR_RT_STAGE = 8'h4a;

	// control register field positions
	localparam int CTRL_WIDE_BIT = 3;
	localparam int CTRL_ACT_LO = 8;
	localparam int CTRL_ACT_HI = 9;

	// reset values and the all-ones wrap compare word
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] WORD_ONES = 16'hffff;
	localparam logic [31:0] BC_ZERO = 32'h0000_0000;

	// remote-terminal action codes
	typedef enum logic [1:0] {
		TTCA_ACT_NONE = 2'b00,
		TTCA_ACT_CLEAR = 2'b01,
		TTCA_ACT_LOAD = 2'b10,
		TTCA_ACT_IDLE = 2'b11
	} ttca_action_t;

	// writable control state
	typedef struct packed {
		ttca_action_t rtAction;
		logic bcWideCountSelect;
	} ttca_ctrl_t;

	// one register port request
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
	} ttca_req_t;
endpackage

// File: bench/ttca_time_tag_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ttca_time_tag_tb
	import ttca_pkg::*;
;
	// ----------------------------------------
	// stimulus and design
	// ----------------------------------------
	logic mclk;
	logic rst;
	ttca_req_t req;
	logic [15:0] rdData;
	logic rdValid;
	logic [3:0] pins; // bcTick, rtTick, bcLoad, bcCapture
	int mismatches;
	int checksDone;

	ttca_time_tag i_ttca_time_tag (
		.mclk(mclk),
		.rst(rst),
		.req(req),
		.rdData(rdData),
		.rdValid(rdValid),
		.bcTick(pins[0]),
		.rtTick(pins[1]),
		.bcLoad(pins[2]),
		.bcCapture(pins[3])
	);

	// clock toggles every 50 ns, a full period of 100 ns
	always #50 mclk = ~mclk;

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// strobe is dropped on the edge that takes it, so back-to-back calls never collide
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
		@(posedge mclk);
		req.wrEn <= 1'b0;
	endtask

	// answer lands on the taking edge itself, looked at once it settles
	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk);
		req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 16'h0000};
		@(posedge mclk);
		req.rdEn <= 1'b0;
		#1;
		`CHK({rdValid, rdData}, {1'b1, e})
	endtask

	// n consecutive edges see the pin high
	task automatic pulse(input int i, input int n);
		repeat (n) begin
			@(posedge mclk);
			pins[i] <= 1'b1;
		end
		@(posedge mclk);
		pins[i] <= 1'b0;
	endtask

	// actions take two edges to finish, so wait that fixed span
	task automatic act(input logic [15:0] d);
		wr(ADDR_CTRL, d);
		repeat (2) @(posedge mclk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ctrl();
		chk_rd(ADDR_CTRL, 16'h0000);
		wr(ADDR_CTRL, 16'hfcf7);
		chk_rd(ADDR_CTRL, 16'h0000);
		wr(ADDR_CTRL, 16'h0008);
		chk_rd(ADDR_CTRL, 16'h0008);
		wr(ADDR_CTRL, 16'h0000);
	endtask

	task automatic t_rt();
		pulse(1, 5);
		act(16'h0300);
		chk_rd(ADDR_RT_COUNT, 16'h0005);
		wr(ADDR_RT_STAGE, 16'hbeef);
		act(16'h0100);
		chk_rd(ADDR_RT_COUNT, 16'h0000);
		chk_rd(ADDR_CTRL, 16'h0000);
		act(16'h0200);
		chk_rd(ADDR_RT_COUNT, 16'hbeef);
		chk_rd(ADDR_CTRL, 16'h0000);
	endtask

	// narrow counter wraps without carrying into the upper word
	task automatic t_bc16();
		wr(ADDR_BC_STAGE_LO, 16'hfffe);
		wr(ADDR_BC_STAGE_HI, 16'h1234);
		chk_rd(ADDR_BC_STAGE_HI, 16'h0000);
		pulse(2, 1);
		pulse(0, 3);
		chk_rd(ADDR_BC_COUNT_LO, 16'h0001);
		chk_rd(ADDR_BC_COUNT_HI, 16'h0000);
		pulse(3, 1);
		chk_rd(ADDR_BC_STAGE_LO, 16'h0001);
		chk_rd(ADDR_BC_STAGE_HI, 16'h0000);
	endtask

	task automatic t_bc32();
		wr(ADDR_CTRL, 16'h0008);
		wr(ADDR_BC_STAGE_HI, 16'h1234);
		wr(ADDR_BC_STAGE_LO, 16'hffff);
		pulse(2, 1);
		pulse(0, 1);
		chk_rd(ADDR_BC_COUNT_HI, 16'h1235);
		chk_rd(ADDR_BC_COUNT_LO, 16'h0000);
		pulse(3, 1);
		chk_rd(ADDR_BC_STAGE_HI, 16'h1235);
		chk_rd(ADDR_BC_STAGE_LO, 16'h0000);
	endtask

	// a reset in mid-run must drop wide mode and every count back to zero
	task automatic t_reset();
		chk_rd(ADDR_RT_STAGE, 16'hbeef);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		chk_rd(ADDR_CTRL, 16'h0000);
		chk_rd(ADDR_BC_COUNT_HI, 16'h0000);
		chk_rd(ADDR_BC_COUNT_LO, 16'h0000);
		chk_rd(ADDR_RT_COUNT, 16'h0000);
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// main sequence, reset held for three edges
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		req = '0;
		pins = 4'h0;
		mismatches = 0;
		checksDone = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_ctrl();
		t_rt();
		t_bc16();
		t_bc32();
		t_reset();
		final_report();
	end

	// the whole run needs about 100 cycles; 4000 means a hang
	initial begin
		#(100 * 4000);
		mismatches++;
		final_report();
	end
endmodule
